// File: hw/oag_params.svh
// Constants for the operand address generator: register indexes, field
// positions, reset values and literal widths.
// Assumes inclusion by bare name from the design file.
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

// ==========================================================================
// Register indexes on the plain register port.
`define OAG_IDX_CTRL 4'h0
`define OAG_IDX_XS 4'h1
`define OAG_IDX_XE 4'h2
`define OAG_IDX_YS 4'h3
`define OAG_IDX_YE 4'h4
`define OAG_IDX_STAT 4'h5

// ==========================================================================
// Reset values.
`define OAG_CTRL_RST 16'h00FF
`define OAG_BOUND_RST 16'h0000
`define OAG_DEFAULT_WORKING_REG_RST 16'h0000

// ==========================================================================
// Control field positions and the disabling select value.
`define OAG_XSEL_LSB 0
`define OAG_YSEL_LSB 4
`define OAG_SEL_W 4
`define OAG_XEN_BIT 15
`define OAG_YEN_BIT 14
`define OAG_SEL_OFF 4'hF

// ==========================================================================
// Literal and address field widths.
`define OAG_NEAR_W 13
`define OAG_LIT5_W 5
`define OAG_LIT8_W 8
`define OAG_INTERRUPT_DISABLE_OP_W 14
`define OAG_PF_CODE_W 2
`define OAG_PF_SIGN_BIT 2

`endif

// File: hw/oag_pkg.sv
// Types shared by the operand address generator.
// Assumes nothing beyond a SystemVerilog compiler.
package oag_pkg;

  // ========================================================================
  // Addressing modes of one address lane.
  typedef enum logic [3:0] {
    M_NONE,
    M_FILE_NEAR,
    M_FILE_FULL,
    M_REG_DIRECT,
    M_IND,
    M_IND_POST,
    M_IND_PRE,
    M_INDEXED,
    M_LIT_OFS,
    M_LIT5,
    M_LIT8,
    M_LIT16,
    M_BRANCH,
    M_INTERRUPT_DISABLE_OP,
    M_PF_IND,
    M_PF_POST
  } oag_mode_t;

  // Prefetch indexed is selected by M_PF_IND with a nonzero offset flag.

endpackage : oag_pkg

// File: hw/oag_core.sv
// Operand address generator with circular-buffer correction.
// Assumes a synchronous core that presents one request per cycle and
// reads the results one cycle later; registers sit on a plain port.
//
// Operation
// RULE_01: File-register address is 13 bits, near space.
// RULE_02: MCU operand one is register direct.
// RULE_03: Plain indirect uses pointer, pointer unchanged.
// RULE_04: Post-modify uses old pointer, then steps it.
// RULE_05: Pre-modify steps pointer, uses new value.
// RULE_06: Indexed address is pointer plus offset register.
// RULE_07: Literal offset address is pointer plus literal.
// RULE_08: Move supports indexed, 8 and 16-bit literals.
// RULE_09: Move lanes share one 4-bit offset field.
// RULE_10: Prefetch uses four pointers, two per space.
// RULE_11: Prefetch indexing only on second pointers.
// RULE_12: Prefetch steps are 2, 4 or 6 only.
// RULE_13: Branch literal signed 16, disable literal 14.
// RULE_14: One circular buffer each in X, Y.
// RULE_15: Software avoids frame and stack pointers here.
// RULE_16: Power-of-two buffers are checked both ways.
// RULE_17: Bounds from start, end; length from difference.
// RULE_18: Y circular addresses have bit zero cleared.
// RULE_19: Select fields at [3:0], [7:4]; 1111 disables.
// RULE_20: Enable bits 15 and 14 gate each space.
// RULE_21: Bound checks are inequalities, catch jumps past.
// RULE_22: Corrected pointer written back only when modified.
// RULE_23: Wrap by subtracting or adding buffer length.
//
// The address-and-strobe port and the register offsets were decided locally.
`include "oag_params.svh"
`timescale 1ns/10ps
`default_nettype none

module oag_core #(
  parameter int DW = 16,
  parameter int NUM_DEFAULT_WORKING_REG = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata_q,
  // Working register load port.
  input wire logic default_working_reg_we,
  input wire logic [3:0] default_working_reg_idx,
  input wire logic [15:0] default_working_reg_wdata,
  // Address request.
  input wire logic req_valid,
  input wire oag_pkg::oag_mode_t req0_mode,
  input wire logic [3:0] req0_ptr,
  input wire logic [15:0] req0_lit,
  input wire oag_pkg::oag_mode_t req1_mode,
  input wire logic [3:0] req1_ptr,
  input wire logic [15:0] req1_lit,
  input wire logic [3:0] req_ofs,
  input wire logic req_pf_indexed,
  // Results.
  output logic ack_q,
  output logic err_q,
  output logic [15:0] ea0_q,
  output logic [15:0] ea1_q
);

  // ========================================================================
  // Elaboration checks.
  if (DW != 16) begin : g_bad_dw
    $error("oag_core serves 16-bit data only.");
  end
  if (NUM_DEFAULT_WORKING_REG != 16) begin : g_bad_nw
    $error("oag_core needs exactly sixteen working registers.");
  end

  // ========================================================================
  // Configuration registers and working registers.
  logic [15:0] ctrl_q;
  logic [15:0] xs_q;
  logic [15:0] xe_q;
  logic [15:0] ys_q;
  logic [15:0] ye_q;
  logic [1:0] hit_q;
  logic [15:0] default_working_reg_q [NUM_DEFAULT_WORKING_REG];

  wire logic [3:0] x_sel = ctrl_q[`OAG_XSEL_LSB +: `OAG_SEL_W]; // RULE_19
  wire logic [3:0] y_sel = ctrl_q[`OAG_YSEL_LSB +: `OAG_SEL_W]; // RULE_19
  wire logic x_on = ctrl_q[`OAG_XEN_BIT] && (x_sel != `OAG_SEL_OFF); // RULE_20
  wire logic y_on = ctrl_q[`OAG_YEN_BIT] && (y_sel != `OAG_SEL_OFF); // RULE_20

  // ========================================================================
  // Circular correction of one address. Returns the hit flag above it.
  // Non power-of-two buffers are only checked in the step direction,
  // because their other bound need not be aligned.
  function automatic logic [16:0] wrap(input logic [15:0] a, input logic neg,
                                       input logic ysp, input logic [3:0] p);
    logic on;
    logic [15:0] s;
    logic [15:0] e;
    logic [16:0] len;
    logic pow2;
    logic [15:0] r;
    logic hit;
    on = ysp ? (y_on && (p == y_sel)) : (x_on && (p == x_sel)); // RULE_14
    s = ysp ? ys_q : xs_q; // RULE_17
    e = ysp ? ye_q : xe_q; // RULE_17
    len = {1'b0, e} - {1'b0, s} + 17'h0_0001; // RULE_17
    pow2 = (len & (len - 17'h0_0001)) == 17'h0_0000; // RULE_16
    r = a;
    hit = 1'b0;
    if (on && (pow2 || !neg) && (a > e)) begin // RULE_21
      r = a - len[15:0]; // RULE_23
      hit = 1'b1;
    end else if (on && (pow2 || neg) && (a < s)) begin // RULE_21
      r = a + len[15:0]; // RULE_23
      hit = 1'b1;
    end
    if (on && ysp) begin
      r[0] = 1'b0; // RULE_18
    end
    return {hit, r};
  endfunction : wrap

  // ========================================================================
  // Two address lanes: source and destination, or X and Y for prefetch.
  oag_pkg::oag_mode_t mode [2];
  logic [3:0] ptr [2];
  logic [15:0] lit [2];
  logic [15:0] ea_d [2];
  logic [15:0] np_d [2];
  logic [3:0] pidx [2];
  logic wb [2];
  logic hit [2];
  logic bad [2];

  assign mode[0] = req0_mode;
  assign mode[1] = req1_mode;
  assign ptr[0] = req0_ptr;
  assign ptr[1] = req1_ptr;
  assign lit[0] = req0_lit;
  assign lit[1] = req1_lit;

  // Both lanes read the same offset register field.
  wire logic [15:0] ofs_val = default_working_reg_q[req_ofs]; // RULE_09

  for (genvar l = 0; l < 2; l++) begin : g_lane
    always_comb begin
      logic pf;
      logic ysp;
      logic [15:0] pv;
      logic [15:0] step;
      logic [15:0] mag;
      logic [1:0] code;
      logic [16:0] w;
      pf = (mode[l] == oag_pkg::M_PF_IND) || (mode[l] == oag_pkg::M_PF_POST);
      ysp = pf && (l == 1); // RULE_10
      pidx[l] = pf ? {3'b100, ptr[l][0]} | 4'(l << 1) : ptr[l]; // RULE_10
      pv = default_working_reg_q[pidx[l]];
      code = lit[l][`OAG_PF_CODE_W-1:0];
      mag = {13'h0000, code, 1'b0}; // RULE_12
      step = (mode[l] == oag_pkg::M_PF_POST) ?
             (lit[l][`OAG_PF_SIGN_BIT] ? 16'h0000 - mag : mag) : lit[l];
      ea_d[l] = pv;
      np_d[l] = pv;
      wb[l] = 1'b0;
      hit[l] = 1'b0;
      bad[l] = 1'b0;
      w = 17'h0_0000;
      unique case (mode[l])
        oag_pkg::M_NONE: ea_d[l] = 16'h0000;
        oag_pkg::M_FILE_NEAR: ea_d[l] = 16'(lit[l][`OAG_NEAR_W-1:0]); // RULE_01
        oag_pkg::M_FILE_FULL: ea_d[l] = lit[l]; // RULE_01
        oag_pkg::M_REG_DIRECT: ea_d[l] = pv; // RULE_02
        oag_pkg::M_IND: ea_d[l] = pv; // RULE_03
        oag_pkg::M_IND_POST: begin
          w = wrap(pv + step, step[15], ysp, pidx[l]); // RULE_04
          np_d[l] = w[15:0];
          hit[l] = w[16];
          wb[l] = 1'b1; // RULE_22
        end
        oag_pkg::M_IND_PRE: begin
          w = wrap(pv + step, step[15], ysp, pidx[l]); // RULE_05
          ea_d[l] = w[15:0];
          np_d[l] = w[15:0];
          hit[l] = w[16];
          wb[l] = 1'b1; // RULE_22
        end
        oag_pkg::M_INDEXED: begin
          w = wrap(pv + ofs_val, ofs_val[15], ysp, pidx[l]); // RULE_06
          ea_d[l] = w[15:0];
          hit[l] = w[16];
        end
        oag_pkg::M_LIT_OFS: begin
          w = wrap(pv + lit[l], lit[l][15], ysp, pidx[l]); // RULE_07
          ea_d[l] = w[15:0];
          hit[l] = w[16];
        end
        oag_pkg::M_LIT5: ea_d[l] = 16'(lit[l][`OAG_LIT5_W-1:0]); // RULE_02
        oag_pkg::M_LIT8: ea_d[l] = 16'(lit[l][`OAG_LIT8_W-1:0]); // RULE_08
        oag_pkg::M_LIT16: ea_d[l] = lit[l]; // RULE_08
        oag_pkg::M_BRANCH: ea_d[l] = lit[l]; // RULE_13
        oag_pkg::M_INTERRUPT_DISABLE_OP: ea_d[l] = 16'(lit[l][`OAG_INTERRUPT_DISABLE_OP_W-1:0]); // RULE_13
        oag_pkg::M_PF_IND: begin
          if (req_pf_indexed) begin
            bad[l] = !ptr[l][0]; // RULE_11
            w = wrap(pv + ofs_val, ofs_val[15], ysp, pidx[l]);
            ea_d[l] = w[15:0];
            hit[l] = w[16];
          end else begin
            w = wrap(pv, 1'b0, ysp, pidx[l]);
            ea_d[l] = w[15:0];
          end
        end
        oag_pkg::M_PF_POST: begin
          bad[l] = (code == 2'b00); // RULE_12
          w = wrap(pv + step, step[15], ysp, pidx[l]);
          np_d[l] = w[15:0];
          hit[l] = w[16];
          wb[l] = !bad[l]; // RULE_22
        end
      endcase
    end
  end

  // ========================================================================
  // Register decode.
  wire logic sel_ctrl = reg_addr == `OAG_IDX_CTRL;
  wire logic sel_xs = reg_addr == `OAG_IDX_XS;
  wire logic sel_xe = reg_addr == `OAG_IDX_XE;
  wire logic sel_ys = reg_addr == `OAG_IDX_YS;
  wire logic sel_ye = reg_addr == `OAG_IDX_YE;
  wire logic sel_st = reg_addr == `OAG_IDX_STAT;
  wire logic [15:0] rd_mux = sel_ctrl ? ctrl_q :
                             sel_xs ? xs_q :
                             sel_xe ? xe_q :
                             sel_ys ? ys_q :
                             sel_ye ? ye_q :
                             sel_st ? {14'h0000, hit_q} : 16'h0000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `OAG_CTRL_RST;
      xs_q <= `OAG_BOUND_RST;
      xe_q <= `OAG_BOUND_RST;
      ys_q <= `OAG_BOUND_RST;
      ye_q <= `OAG_BOUND_RST;
      reg_rdata_q <= 16'h0000;
    end else begin
      if (reg_we && sel_ctrl) ctrl_q <= reg_wdata;
      if (reg_we && sel_xs) xs_q <= reg_wdata;
      if (reg_we && sel_xe) xe_q <= reg_wdata;
      if (reg_we && sel_ys) ys_q <= reg_wdata;
      if (reg_we && sel_ye) ye_q <= reg_wdata;
      reg_rdata_q <= reg_re ? rd_mux : 16'h0000;
    end
  end

  // ========================================================================
  // Working registers. A load from the core beats a pointer write-back,
  // and lane one beats lane zero, so the last writer in program order wins.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_DEFAULT_WORKING_REG; i++) begin
        default_working_reg_q[i] <= `OAG_DEFAULT_WORKING_REG_RST;
      end
    end else begin
      if (req_valid && wb[0]) default_working_reg_q[pidx[0]] <= np_d[0]; // RULE_22
      if (req_valid && wb[1]) default_working_reg_q[pidx[1]] <= np_d[1]; // RULE_22
      if (default_working_reg_we) default_working_reg_q[default_working_reg_idx] <= default_working_reg_wdata;
    end
  end

  // ========================================================================
  // Results, one cycle after the request.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      ea0_q <= 16'h0000;
      ea1_q <= 16'h0000;
      hit_q <= 2'b00;
    end else begin
      ack_q <= req_valid;
      err_q <= req_valid && (bad[0] || bad[1]);
      if (req_valid) begin
        ea0_q <= ea_d[0];
        ea1_q <= ea_d[1];
        hit_q <= {hit[1], hit[0]};
      end
    end
  end

  // ========================================================================
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  wire logic [15:0] p0_val = default_working_reg_q[req0_ptr];

  a_ind_ea_ptr: assert property ( // RULE_03
    req_valid && req0_mode == oag_pkg::M_IND && !default_working_reg_we
      && !(wb[1] && pidx[1] == req0_ptr) |=>
      ea0_q == $past(p0_val) && default_working_reg_q[$past(req0_ptr)] == ea0_q)
    else $error("Plain indirect address or pointer wrong.");
  a_post_old_ea: assert property ( // RULE_04
    req_valid && req0_mode == oag_pkg::M_IND_POST |=> ack_q && ea0_q == $past(p0_val))
    else $error("Post-modify did not use the old pointer.");
  a_indexed_sum: assert property ( // RULE_06
    req_valid && req0_mode == oag_pkg::M_INDEXED && !x_on |=>
      ea0_q == $past(p0_val + ofs_val))
    else $error("Indexed address is not pointer plus offset.");
  a_file_near: assert property ( // RULE_01
    req_valid && req0_mode == oag_pkg::M_FILE_NEAR |=> ea0_q[15:13] == 3'b000)
    else $error("Near file address leaves the near space.");
  a_interrupt_disable_op_width: assert property ( // RULE_13
    req_valid && req0_mode == oag_pkg::M_INTERRUPT_DISABLE_OP |=> ea0_q[15:14] == 2'b00)
    else $error("Disable literal wider than 14 bits.");
  a_x_off_nohit: assert property ( // RULE_20
    req_valid && !x_on && req0_mode != oag_pkg::M_PF_IND
      && req0_mode != oag_pkg::M_PF_POST |=> !hit_q[0])
    else $error("X correction while disabled.");
  a_y_word_align: assert property ( // RULE_18
    req_valid && y_on && req1_mode == oag_pkg::M_PF_IND && pidx[1] == y_sel
      |=> ea1_q[0] == 1'b0)
    else $error("Y circular address is odd.");
  a_pf_step_err: assert property ( // RULE_12
    req_valid && req0_mode == oag_pkg::M_PF_POST && req0_lit[1:0] == 2'b00 |=> err_q)
    else $error("Illegal prefetch step not flagged.");
  a_pf_index_err: assert property ( // RULE_11
    req_valid && req_pf_indexed
      && ((req1_mode == oag_pkg::M_PF_IND && !req1_ptr[0])
      || (req0_mode == oag_pkg::M_PF_IND && !req0_ptr[0])) |=> err_q)
    else $error("Indexing on first prefetch pointer not flagged.");

  c_x_wrap: cover property (req_valid && x_on && hit[0] ##1 ack_q);
  c_y_wrap: cover property (req_valid && y_on && hit[1] ##1 ack_q);
  c_pf_pair: cover property (req_valid && req0_mode == oag_pkg::M_PF_POST
    && req1_mode == oag_pkg::M_PF_POST ##1 !err_q);
  c_ofs_wrap: cover property (req_valid && req0_mode == oag_pkg::M_LIT_OFS
    && hit[0] ##1 ack_q);
  c_pf_index: cover property (req_valid && req_pf_indexed
    && req1_mode == oag_pkg::M_PF_IND ##1 !err_q);

endmodule : oag_core

`default_nettype wire

// File: dv/oag_core_bench.sv
// Self-checking bench for the operand address generator.
// Assumes oag_core with registered results one cycle after each strobe.
`timescale 1ns/10ps
`default_nettype none

module oag_core_bench;

  // ==========================================================================
  // Stimulus and observation signals.
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [15:0] reg_rdata_q;
  logic default_working_reg_we = 1'b0;
  logic [3:0] default_working_reg_idx = 4'h0;
  logic [15:0] default_working_reg_wdata = 16'h0000;
  logic req_valid = 1'b0;
  oag_pkg::oag_mode_t req0_mode = oag_pkg::M_NONE;
  oag_pkg::oag_mode_t req1_mode = oag_pkg::M_NONE;
  logic [3:0] req0_ptr = 4'h0;
  logic [3:0] req1_ptr = 4'h0;
  logic [15:0] req0_lit = 16'h0000;
  logic [15:0] req1_lit = 16'h0000;
  logic [3:0] req_ofs = 4'h0;
  logic req_pf_indexed = 1'b0;
  logic ack_q;
  logic err_q;
  logic [15:0] ea0_q;
  logic [15:0] ea1_q;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  oag_core oag_core_inst (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(reg_rdata_q),
    .default_working_reg_we(default_working_reg_we), .default_working_reg_idx(default_working_reg_idx), .default_working_reg_wdata(default_working_reg_wdata),
    .req_valid(req_valid), .req0_mode(req0_mode), .req0_ptr(req0_ptr),
    .req0_lit(req0_lit), .req1_mode(req1_mode), .req1_ptr(req1_ptr),
    .req1_lit(req1_lit), .req_ofs(req_ofs), .req_pf_indexed(req_pf_indexed),
    .ack_q(ack_q), .err_q(err_q), .ea0_q(ea0_q), .ea1_q(ea1_q)
  );

  always #4 sys_clk = ~sys_clk;

  // The ceiling is far above the roughly 140 cycles the tests need.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : reg_rd

  task automatic wload(input logic [3:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    default_working_reg_we <= 1'b1;
    default_working_reg_idx <= i;
    default_working_reg_wdata <= d;
    @(posedge sys_clk);
    default_working_reg_we <= 1'b0;
  endtask : wload

  task automatic rq(input oag_pkg::oag_mode_t m0, input logic [3:0] p0,
                    input logic [15:0] l0, input oag_pkg::oag_mode_t m1,
                    input logic [3:0] p1, input logic [15:0] l1, input logic pfi);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req0_mode <= m0;
    req0_ptr <= p0;
    req0_lit <= l0;
    req1_mode <= m1;
    req1_ptr <= p1;
    req1_lit <= l1;
    req_ofs <= 4'h2;
    req_pf_indexed <= pfi;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    check({15'h0000, ack_q}, 16'h0001);
  endtask : rq

  task automatic rq0(input oag_pkg::oag_mode_t m, input logic [3:0] p, input logic [15:0] l);
    rq(m, p, l, oag_pkg::M_NONE, 4'h0, 16'h0000, 1'b0);
  endtask : rq0

  // ==========================================================================
  // Scenarios.
  task automatic t_regs;
    logic [15:0] d;
    reg_rd(4'h0, d);
    check(d, 16'h00FF);
    reg_rd(4'h1, d);
    check(d, 16'h0000);
    reg_wr(4'h4, 16'hBEEF);
    reg_rd(4'h4, d);
    check(d, 16'hBEEF);
    @(posedge sys_clk);
    #1;
    check(reg_rdata_q, 16'h0000);
    reg_wr(4'h5, 16'hFFFF);
    reg_rd(4'h5, d);
    check(d, 16'h0000);
    reg_rd(4'h9, d);
    check(d, 16'h0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_indirect;
    wload(4'h1, 16'h0100);
    wload(4'h2, 16'h0010);
    wload(4'h3, 16'h0300);
    rq0(oag_pkg::M_IND, 4'h1, 16'h0000);
    check(ea0_q, 16'h0100);
    rq0(oag_pkg::M_IND_POST, 4'h1, 16'h0002);
    check(ea0_q, 16'h0100);
    rq0(oag_pkg::M_IND, 4'h1, 16'h0000);
    check(ea0_q, 16'h0102);
    rq0(oag_pkg::M_IND_PRE, 4'h1, 16'hFFFC);
    check(ea0_q, 16'h00FE);
    rq0(oag_pkg::M_IND, 4'h1, 16'h0000);
    check(ea0_q, 16'h00FE);
    rq0(oag_pkg::M_LIT_OFS, 4'h1, 16'h0020);
    check(ea0_q, 16'h011E);
    rq(oag_pkg::M_INDEXED, 4'h1, 16'h0000, oag_pkg::M_INDEXED, 4'h3, 16'h0000, 1'b0);
    check(ea0_q, 16'h010E);
    check(ea1_q, 16'h0310);
    rq0(oag_pkg::M_IND, 4'h1, 16'h0000);
    check(ea0_q, 16'h00FE);
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_literals;
    rq0(oag_pkg::M_FILE_NEAR, 4'h0, 16'hFFFF);
    check(ea0_q, 16'h1FFF);
    rq0(oag_pkg::M_FILE_FULL, 4'h0, 16'hFFFF);
    check(ea0_q, 16'hFFFF);
    rq0(oag_pkg::M_REG_DIRECT, 4'h2, 16'h0000);
    check(ea0_q, 16'h0010);
    rq0(oag_pkg::M_LIT5, 4'h0, 16'hFFFF);
    check(ea0_q, 16'h001F);
    rq0(oag_pkg::M_LIT8, 4'h0, 16'h1234);
    check(ea0_q, 16'h0034);
    rq0(oag_pkg::M_LIT16, 4'h0, 16'hA5C3);
    check(ea0_q, 16'hA5C3);
    rq0(oag_pkg::M_BRANCH, 4'h0, 16'h8002);
    check(ea0_q, 16'h8002);
    rq0(oag_pkg::M_INTERRUPT_DISABLE_OP, 4'h0, 16'hFFFF);
    check(ea0_q, 16'h3FFF);
    $display("test literals done");
  endtask : t_literals

  task automatic t_prefetch;
    logic [15:0] e;
    wload(4'h8, 16'h0800);
    wload(4'h9, 16'h0900);
    wload(4'hB, 16'h0B00);
    e = 16'h0800;
    for (int c = 1; c <= 3; c++) begin
      rq0(oag_pkg::M_PF_POST, 4'h8, 16'(c));
      check(ea0_q, e);
      e = e + 16'(2 * c);
    end
    rq0(oag_pkg::M_PF_POST, 4'h8, 16'h0005);
    check(ea0_q, e);
    check({15'h0000, err_q}, 16'h0000);
    rq0(oag_pkg::M_PF_POST, 4'h8, 16'h0000);
    check({15'h0000, err_q}, 16'h0001);
    rq0(oag_pkg::M_PF_IND, 4'h8, 16'h0000);
    check(ea0_q, e - 16'h0002);
    rq(oag_pkg::M_PF_IND, 4'h9, 16'h0000, oag_pkg::M_PF_IND, 4'hB, 16'h0000, 1'b1);
    check(ea0_q, 16'h0910);
    check(ea1_q, 16'h0B10);
    check({15'h0000, err_q}, 16'h0000);
    rq(oag_pkg::M_PF_IND, 4'h8, 16'h0000, oag_pkg::M_NONE, 4'h0, 16'h0000, 1'b1);
    check({15'h0000, err_q}, 16'h0001);
    $display("test prefetch done");
  endtask : t_prefetch

  task automatic t_circ_x;
    logic [15:0] d;
    reg_wr(4'h1, 16'h1100);
    reg_wr(4'h2, 16'h1163);
    reg_wr(4'h0, 16'h80F1);
    wload(4'h1, 16'h1160);
    rq0(oag_pkg::M_IND_POST, 4'h1, 16'h0002);
    check(ea0_q, 16'h1160);
    rq0(oag_pkg::M_IND_POST, 4'h1, 16'h0002);
    rq0(oag_pkg::M_IND, 4'h1, 16'h0000);
    check(ea0_q, 16'h1100);
    wload(4'h1, 16'h1162);
    rq0(oag_pkg::M_IND_PRE, 4'h1, 16'h0004);
    check(ea0_q, 16'h1102);
    reg_rd(4'h5, d);
    check(d, 16'h0001);
    rq0(oag_pkg::M_LIT_OFS, 4'h1, 16'h0064);
    check(ea0_q, 16'h1102);
    rq0(oag_pkg::M_IND, 4'h1, 16'h0000);
    check(ea0_q, 16'h1102);
    // Power-of-two buffer wraps below its start as well.
    reg_wr(4'h1, 16'h1000);
    reg_wr(4'h2, 16'h103F);
    wload(4'h1, 16'h1000);
    rq0(oag_pkg::M_IND_PRE, 4'h1, 16'hFFFE);
    check(ea0_q, 16'h103E);
    wload(4'h1, 16'h103E);
    reg_wr(4'h0, 16'h00F1);
    rq0(oag_pkg::M_IND_PRE, 4'h1, 16'h0004);
    check(ea0_q, 16'h1042);
    reg_wr(4'h0, 16'h80FF);
    rq0(oag_pkg::M_IND_PRE, 4'h1, 16'h0004);
    check(ea0_q, 16'h1046);
    $display("test circular x done");
  endtask : t_circ_x

  task automatic t_circ_y;
    logic [15:0] d;
    reg_wr(4'h3, 16'h2000);
    reg_wr(4'h4, 16'h201F);
    reg_wr(4'h0, 16'h40AF);
    wload(4'hA, 16'h201E);
    rq(oag_pkg::M_NONE, 4'h0, 16'h0000, oag_pkg::M_PF_POST, 4'hA, 16'h0001, 1'b0);
    check(ea1_q, 16'h201E);
    reg_rd(4'h5, d);
    check(d, 16'h0002);
    rq(oag_pkg::M_NONE, 4'h0, 16'h0000, oag_pkg::M_PF_IND, 4'hA, 16'h0000, 1'b0);
    check(ea1_q, 16'h2000);
    wload(4'hA, 16'h2003);
    rq(oag_pkg::M_NONE, 4'h0, 16'h0000, oag_pkg::M_PF_IND, 4'hA, 16'h0000, 1'b0);
    check(ea1_q, 16'h2002);
    $display("test circular y done");
  endtask : t_circ_y

  // ==========================================================================
  // Sequence and verdict.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_indirect();
    t_literals();
    t_prefetch();
    t_circ_x();
    t_circ_y();
    end_sim();
  end

endmodule : oag_core_bench

`default_nettype wire
